// ===== include/sso_pkg.sv
package sso_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int QW          = 16;      // Width of speed, torque and count quantities
   localparam int FAULT_W     = 3;       // Fault code width
   localparam int FACTOR_W    = 8;       // Pulse factor width
   localparam int OUT_SEL_W   = 2;       // Unused; terminal allocation selects are SEL_W (4) bits wide
   localparam int N_TERM      = 4;       // Number of output terminals

   // ----------------------------------------------------------------
   // Control modes and selector codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SSO_MODE_POS = 2'h0,
      SSO_MODE_SPD = 2'h1,
      SSO_MODE_TRQ = 2'h2
   } sso_mode_e;

   localparam logic [1:0] TRQ_SEL_ANALOG    = 2'h1;   // Analog torque limit always applies
   localparam logic [1:0] TRQ_SEL_ANALOG_EXT = 2'h3;  // Analog limit while external limit on
   localparam logic [1:0] SPD_SEL_ANALOG    = 2'h1;   // Analog speed limit applies
   localparam logic       FACTOR_SW_ON      = 1'b1;   // Pulse factor switching enabled
   localparam logic [FACTOR_W-1:0] FACTOR_ONE = 8'h01;

   // ----------------------------------------------------------------
   // Warning threshold: 115 percent of rated torque
   // ----------------------------------------------------------------
   localparam int OVERLOAD_PCT = 115;
   localparam int PCT_BASE     = 100;

   // ----------------------------------------------------------------
   // Status selectors for terminal allocation
   // ----------------------------------------------------------------
   localparam int N_STAT      = 10;
   localparam int SEL_W       = 4;
   localparam logic [SEL_W-1:0] ST_POS_A    = 4'h0;
   localparam logic [SEL_W-1:0] ST_SPD_MT   = 4'h1;
   localparam logic [SEL_W-1:0] ST_ROT      = 4'h2;
   localparam logic [SEL_W-1:0] ST_READY    = 4'h3;
   localparam logic [SEL_W-1:0] ST_TRQ_LIM  = 4'h4;
   localparam logic [SEL_W-1:0] ST_VEL_LIM  = 4'h5;
   localparam logic [SEL_W-1:0] ST_BRAKE    = 4'h6;
   localparam logic [SEL_W-1:0] ST_WARN     = 4'h7;
   localparam logic [SEL_W-1:0] ST_PFACT    = 4'h8;
   localparam logic [SEL_W-1:0] ST_POS_B    = 4'h9;
   localparam logic [SEL_W-1:0] ST_POS_SPD  = 4'hA;   // Shared pair: done flag a or speed match

   // Default allocation of terminals 0..3
   localparam logic [N_TERM*SEL_W-1:0] TERM_ALLOC_RST = {ST_READY, ST_ROT, ST_POS_SPD, ST_POS_SPD};

   // ----------------------------------------------------------------
   // Brake timing
   // ----------------------------------------------------------------
   localparam int BRK_W = 16;   // Width of brake delay counters (control cycles)

   typedef enum logic [1:0] {
      SSO_BRK_HOLD    = 2'b00,   // Brake engaged, motor off
      SSO_BRK_RELEASE = 2'b01,   // Waiting timing one after servo on
      SSO_BRK_RUN     = 2'b11,   // Brake released
      SSO_BRK_STOP    = 2'b10    // Servo off, waiting for speed or timing two
   } sso_brk_e;

endpackage

// ===== rtl/sso_brake_seq.sv
module sso_brake_seq
   import sso_pkg::*;
#(
   parameter int W = BRK_W
) (
   input  wire logic          clk_sys_i,
   input  wire logic          resetn_i,
   input  wire logic          servo_on_i,
   input  wire logic [QW-1:0] speed_abs_i,
   input  wire logic [W-1:0]  brake_timing_one_i,
   input  wire logic [QW-1:0] brake_command_speed_i,
   input  wire logic [W-1:0]  brake_timing_two_i,
   output logic               brake_release_o
);

   sso_brk_e        st_q, st_d;
   logic [W-1:0]    cnt_q, cnt_d;
   logic            rel_q, rel_d;

   // Next state: release after timing one, re-engage on slow speed or timing two
   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      rel_d = rel_q;
      case (st_q)
         SSO_BRK_HOLD: begin
            rel_d = 1'b0;
            if (servo_on_i) begin
               st_d  = SSO_BRK_RELEASE;
               cnt_d = '0;
            end
         end
         SSO_BRK_RELEASE: begin
            cnt_d = cnt_q + 1'b1;
            if (!servo_on_i) begin
               st_d = SSO_BRK_HOLD;
            end else if (cnt_q >= brake_timing_one_i) begin
               st_d  = SSO_BRK_RUN;
               rel_d = 1'b1;
            end
         end
         SSO_BRK_RUN: begin
            if (!servo_on_i) begin
               st_d  = SSO_BRK_STOP;
               cnt_d = '0;
            end
         end
         SSO_BRK_STOP: begin
            cnt_d = cnt_q + 1'b1;
            // Engage early once slow, so a coasting load never drags a locked brake long
            if (speed_abs_i <= brake_command_speed_i || cnt_q >= brake_timing_two_i) begin
               st_d  = SSO_BRK_HOLD;
               rel_d = 1'b0;
            end
         end
         default: begin
            st_d  = SSO_BRK_HOLD;
            rel_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         st_q  <= SSO_BRK_HOLD;
         cnt_q <= '0;
         rel_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         rel_q <= rel_d;
      end
   end

   assign brake_release_o = rel_q;

endmodule

// ===== rtl/sso_status_out.sv
// Summary of operation
// - Fault clears fault-free output, shows fault code
// - Fault-free output low until init done cleanly
// - Done flag a when deviation below range a
// - Done flag b when deviation below range b
// - Done flags off outside position control
// - Speed match when command-speed difference within width
// - Speed match off outside speed control
// - Rotation detect when speed above threshold
// - Ready after main power and init done with no fault
// - Torque limit hit at internal limits
// - Torque limit hit at external limits when enabled
// - Analog torque limit per selector 1 or 3
// - Velocity limit hit at setting or analog limit
// - Velocity limit hit off outside torque control
// - Brake interlock follows timing and speed settings
// - Warning off when torque exceeds 115 percent
// - Warning off when regen energy exceeds capacity
// - Factor active after factor change, off at one
// - Factor switching only when enable equals one
// - Outputs routed to terminals by allocation
// - Fault code is three bits
// - Applied factor output takes factor value while select active
module sso_status_out
   import sso_pkg::*;
(
   input  wire logic                    clk_sys_i,
   input  wire logic                    resetn_i,
   input  wire logic                    init_done_i,
   input  wire logic                    main_power_ok_i,
   input  wire logic                    fault_i,
   input  wire logic [FAULT_W-1:0]      fault_code_i,
   input  wire logic [1:0]              control_mode_i,
   input  wire logic [QW-1:0]           deviation_abs_i,
   input  wire logic [QW-1:0]           position_done_range_a_i,
   input  wire logic [QW-1:0]           position_done_range_b_i,
   input  wire logic signed [QW-1:0]    speed_cmd_i,
   input  wire logic signed [QW-1:0]    speed_i,
   input  wire logic [QW-1:0]           speed_match_width_i,
   input  wire logic [QW-1:0]           rotation_detect_speed_i,
   input  wire logic signed [QW-1:0]    torque_i,
   input  wire logic [QW-1:0]           forward_torque_limit_i,
   input  wire logic [QW-1:0]           reverse_torque_limit_i,
   input  wire logic [QW-1:0]           forward_ext_current_limit_i,
   input  wire logic [QW-1:0]           reverse_ext_current_limit_i,
   input  wire logic                    forward_ext_current_limit_input_i,
   input  wire logic                    reverse_ext_current_limit_input_i,
   input  wire logic [QW-1:0]           analog_torque_input_i,
   input  wire logic [1:0]              torque_input_selector_i,
   input  wire logic [QW-1:0]           velocity_limit_setting_i,
   input  wire logic [QW-1:0]           analog_speed_limit_i,
   input  wire logic [1:0]              speed_input_selector_i,
   input  wire logic                    servo_on_i,
   input  wire logic [BRK_W-1:0]        brake_timing_one_i,
   input  wire logic [QW-1:0]           brake_command_speed_i,
   input  wire logic [BRK_W-1:0]        brake_timing_two_i,
   input  wire logic [QW-1:0]           torque_eff_i,
   input  wire logic [QW-1:0]           rated_torque_i,
   input  wire logic [QW-1:0]           regen_energy_i,
   input  wire logic [QW-1:0]           internal_regen_tolerance_i,
   input  wire logic                    external_resistor_i,
   input  wire logic [QW-1:0]           regen_resistor_capacity_i,
   input  wire logic                    pulse_factor_select_i,
   input  wire logic                    pulse_factor_switch_enable_i,
   input  wire logic [FACTOR_W-1:0]     pulse_factor_value_i,
   input  wire logic [N_TERM*SEL_W-1:0] term_alloc_i,
   output logic                         fault_free_output_o,
   output logic [FAULT_W-1:0]           fault_code_o,
   output logic                         position_done_flag_a_o,
   output logic                         position_done_flag_b_o,
   output logic                         speed_match_output_o,
   output logic                         rotation_detect_output_o,
   output logic                         servo_ready_o,
   output logic                         torque_limit_hit_output_o,
   output logic                         velocity_limit_hit_output_o,
   output logic                         brake_interlock_output_o,
   output logic                         warning_output_o,
   output logic                         pulse_factor_active_output_o,
   output logic [FACTOR_W-1:0]          applied_factor_o,
   output logic [N_TERM-1:0]            term_out_o
);

   // ----------------------------------------------------------------
   // Pin inputs: three-stage synchronisers
   // ----------------------------------------------------------------
   logic [2:0] fcl_q, rcl_q, psel_q;
   logic       fcl_s_q, rcl_s_q, psel_s_q;

   // Change counts only once the last two stages agree
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         fcl_q    <= 3'h0;
         rcl_q    <= 3'h0;
         psel_q   <= 3'h0;
         fcl_s_q  <= 1'b0;
         rcl_s_q  <= 1'b0;
         psel_s_q <= 1'b0;
      end else begin
         fcl_q  <= {fcl_q[1:0], forward_ext_current_limit_input_i};
         rcl_q  <= {rcl_q[1:0], reverse_ext_current_limit_input_i};
         psel_q <= {psel_q[1:0], pulse_factor_select_i};
         if (fcl_q[1] == fcl_q[2]) fcl_s_q <= fcl_q[2];
         if (rcl_q[1] == rcl_q[2]) rcl_s_q <= rcl_q[2];
         if (psel_q[1] == psel_q[2]) psel_s_q <= psel_q[2];
      end
   end

   // ----------------------------------------------------------------
   // Derived magnitudes
   // ----------------------------------------------------------------
   logic [QW-1:0] spd_abs, trq_abs, spd_diff;
   logic signed [QW:0] diff_w;
   logic          trq_fwd;
   logic [QW+7:0] trq_scaled, rated_scaled;

   assign spd_abs  = speed_i[QW-1] ? QW'(-speed_i) : QW'(speed_i);
   assign trq_abs  = torque_i[QW-1] ? QW'(-torque_i) : QW'(torque_i);
   assign trq_fwd  = !torque_i[QW-1];
   assign diff_w   = (QW+1)'(speed_cmd_i) - (QW+1)'(speed_i);
   assign spd_diff = diff_w[QW] ? QW'(-diff_w) : QW'(diff_w);
   assign trq_scaled   = (QW+8)'(torque_eff_i) * (QW+8)'(PCT_BASE);
   assign rated_scaled = (QW+8)'(rated_torque_i) * (QW+8)'(OVERLOAD_PCT);

   // ----------------------------------------------------------------
   // Brake sequencer
   // ----------------------------------------------------------------
   logic brk_rel;

   sso_brake_seq #(
      .W (BRK_W)
   ) u_brake (
      .clk_sys_i             (clk_sys_i),
      .resetn_i              (resetn_i),
      .servo_on_i            (servo_on_i),
      .speed_abs_i           (spd_abs),
      .brake_timing_one_i    (brake_timing_one_i),
      .brake_command_speed_i (brake_command_speed_i),
      .brake_timing_two_i    (brake_timing_two_i),
      .brake_release_o       (brk_rel)
   );

   // ----------------------------------------------------------------
   // Status comparisons
   // ----------------------------------------------------------------
   logic                init_ok_q, init_ok_d;
   logic                ff_d, inp_a_d, inp_b_d, speed_match_output_d, rot_d, rdy_d;
   logic                tlim_d, vlim_d, warn_d, pact_d;
   logic [FAULT_W-1:0]  code_d;
   logic [FACTOR_W-1:0] fact_q, fact_d;
   logic                ext_on, lim_int, lim_ext, lim_ana;

   always_comb begin
      // Init done is sticky; a fault seen before it completes blocks it
      init_ok_d = init_ok_q | (init_done_i & !fault_i);
      ff_d      = init_ok_q & !fault_i;
      code_d    = fault_i ? fault_code_i : '0;
      inp_a_d   = (control_mode_i == SSO_MODE_POS) &&
                  (deviation_abs_i < position_done_range_a_i);
      inp_b_d   = (control_mode_i == SSO_MODE_POS) &&
                  (deviation_abs_i < position_done_range_b_i);
      speed_match_output_d    = (control_mode_i == SSO_MODE_SPD) &&
                  (spd_diff <= speed_match_width_i);
      rot_d     = spd_abs > rotation_detect_speed_i;
      rdy_d     = main_power_ok_i & init_ok_q & !fault_i;
      // Limit reached in the direction the torque acts
      ext_on    = trq_fwd ? fcl_s_q : rcl_s_q;
      lim_int   = trq_abs >= (trq_fwd ? forward_torque_limit_i
                                      : reverse_torque_limit_i);
      lim_ext   = ext_on && trq_abs >= (trq_fwd ? forward_ext_current_limit_i
                                                : reverse_ext_current_limit_i);
      lim_ana   = (trq_abs >= analog_torque_input_i) &&
                  ((torque_input_selector_i == TRQ_SEL_ANALOG) ||
                   (torque_input_selector_i == TRQ_SEL_ANALOG_EXT && ext_on));
      tlim_d    = lim_int | lim_ext | lim_ana;
      vlim_d    = (control_mode_i == SSO_MODE_TRQ) &&
                  ((spd_abs >= velocity_limit_setting_i) ||
                   (speed_input_selector_i == SPD_SEL_ANALOG &&
                    spd_abs >= analog_speed_limit_i));
      // Warning is active-high healthy: low means a warning condition
      warn_d    = !((trq_scaled > rated_scaled) ||
                    (!external_resistor_i &&
                     regen_energy_i > internal_regen_tolerance_i) ||
                    (external_resistor_i &&
                     regen_energy_i > regen_resistor_capacity_i));
      // Factor applies only with switching enabled and select active
      fact_d    = (pulse_factor_switch_enable_i == FACTOR_SW_ON && psel_s_q)
                  ? pulse_factor_value_i : FACTOR_ONE;
      // Active once the applied factor really changed; cleared when back at one
      pact_d    = (fact_q != FACTOR_ONE);
   end

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         init_ok_q                   <= 1'b0;
         fault_free_output_o         <= 1'b0;
         fault_code_o                <= '0;
         position_done_flag_a_o      <= 1'b0;
         position_done_flag_b_o      <= 1'b0;
         speed_match_output_o        <= 1'b0;
         rotation_detect_output_o    <= 1'b0;
         servo_ready_o               <= 1'b0;
         torque_limit_hit_output_o   <= 1'b0;
         velocity_limit_hit_output_o <= 1'b0;
         brake_interlock_output_o    <= 1'b0;
         warning_output_o            <= 1'b1;
         pulse_factor_active_output_o <= 1'b0;
         fact_q                      <= FACTOR_ONE;
      end else begin
         init_ok_q                   <= init_ok_d;
         fault_free_output_o         <= ff_d;
         fault_code_o                <= code_d;
         position_done_flag_a_o      <= inp_a_d;
         position_done_flag_b_o      <= inp_b_d;
         speed_match_output_o        <= speed_match_output_d;
         rotation_detect_output_o    <= rot_d;
         servo_ready_o               <= rdy_d;
         torque_limit_hit_output_o   <= tlim_d;
         velocity_limit_hit_output_o <= vlim_d;
         brake_interlock_output_o    <= brk_rel;
         warning_output_o            <= warn_d;
         pulse_factor_active_output_o <= pact_d;
         fact_q                      <= fact_d;
      end
   end

   assign applied_factor_o = fact_q;

   // ----------------------------------------------------------------
   // Terminal allocation
   // ----------------------------------------------------------------
   logic [N_TERM-1:0] term_d;

   // Selects from the same comparison terms so terminals align with flag outputs
   for (genvar t = 0; t < N_TERM; t++) begin : g_term
      logic [SEL_W-1:0] sel;
      assign sel = term_alloc_i[t*SEL_W +: SEL_W];
      always_comb begin
         case (sel)
            ST_POS_A:   term_d[t] = inp_a_d;
            ST_SPD_MT:  term_d[t] = speed_match_output_d;
            ST_ROT:     term_d[t] = rot_d;
            ST_READY:   term_d[t] = rdy_d;
            ST_TRQ_LIM: term_d[t] = tlim_d;
            ST_VEL_LIM: term_d[t] = vlim_d;
            ST_BRAKE:   term_d[t] = brk_rel;
            ST_WARN:    term_d[t] = warn_d;
            ST_PFACT:   term_d[t] = pact_d;
            ST_POS_B:   term_d[t] = inp_b_d;
            ST_POS_SPD: term_d[t] = inp_a_d | speed_match_output_d;   // Each valid only in its own mode
            default:    term_d[t] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) term_out_o <= '0;
      else           term_out_o <= term_d;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_fault_clears_ok: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      fault_i |=> !fault_free_output_o && fault_code_o == $past(fault_code_i))
      else $error("fault did not clear fault-free output");

   a_no_ok_before_init: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !init_ok_q |=> !fault_free_output_o)
      else $error("fault-free output before init");

   a_done_a_cmp: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (control_mode_i == SSO_MODE_POS && deviation_abs_i < position_done_range_a_i)
      |=> position_done_flag_a_o)
      else $error("done flag a missing");

   a_done_mode_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      control_mode_i != SSO_MODE_POS |=> !position_done_flag_a_o && !position_done_flag_b_o)
      else $error("done flag outside position mode");

   a_match_mode_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      control_mode_i != SSO_MODE_SPD |=> !speed_match_output_o)
      else $error("speed match outside speed mode");

   a_rot_thresh: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      spd_abs > rotation_detect_speed_i |=> rotation_detect_output_o)
      else $error("rotation detect missing");

   a_vlim_mode_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      control_mode_i != SSO_MODE_TRQ |=> !velocity_limit_hit_output_o)
      else $error("velocity limit outside torque mode");

   a_ready_fault: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      fault_i |=> !servo_ready_o)
      else $error("ready during fault");

   a_factor_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      pulse_factor_switch_enable_i != FACTOR_SW_ON [*2] |=> applied_factor_o == FACTOR_ONE)
      else $error("factor applied while switching disabled");

endmodule

// ===== verif/sso_host_model.sv
// ----------------------------------------------------------------
// Host controller that reads the drive status terminals
// ----------------------------------------------------------------
module sso_host_model
   import sso_pkg::*;
(
   input  wire logic               clk_sys_i,
   input  wire logic [N_TERM-1:0]  term_out_i,
   input  wire logic [FAULT_W-1:0] fault_code_i,
   output logic [N_TERM-1:0]       host_term_o,
   output logic [FAULT_W-1:0]      host_code_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Host latches what it sees each cycle, as a polling controller would
   always_ff @(posedge clk_sys_i) begin
      host_term_o <= term_out_i;
      host_code_o <= fault_code_i;
   end
endmodule

// ===== verif/tb_top.sv
module tb_top
   import sso_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Stimulus; limits idle at full scale so nothing trips by accident
   // ----------------------------------------------------------------
   logic clk_sys_i = 1'b0, resetn_i = 1'b0, init_done_i = 1'b0, main_power_ok_i = 1'b0;
   logic fault_i = 1'b0, servo_on_i = 1'b0, external_resistor_i = 1'b0;
   logic forward_ext_current_limit_input_i = 1'b0, reverse_ext_current_limit_input_i = 1'b0;
   logic pulse_factor_select_i = 1'b0, pulse_factor_switch_enable_i = 1'b0;
   logic [FAULT_W-1:0] fault_code_i = 3'h0;
   logic [1:0] control_mode_i = 2'h0, torque_input_selector_i = 2'h0;
   logic [1:0] speed_input_selector_i = 2'h0;
   logic signed [QW-1:0] speed_cmd_i = 16'h0000, speed_i = 16'h0000, torque_i = 16'h0000;
   logic [QW-1:0] deviation_abs_i = 16'h0000, speed_match_width_i = 16'h0000;
   logic [QW-1:0] rotation_detect_speed_i = 16'h0000, torque_eff_i = 16'h0000;
   logic [QW-1:0] regen_energy_i = 16'h0000, brake_command_speed_i = 16'h0000;
   logic [BRK_W-1:0] brake_timing_one_i = 16'h0000, brake_timing_two_i = 16'h0000;
   logic [QW-1:0] position_done_range_a_i = 16'hFFFF, position_done_range_b_i = 16'hFFFF;
   logic [QW-1:0] forward_torque_limit_i = 16'hFFFF, reverse_torque_limit_i = 16'hFFFF;
   logic [QW-1:0] forward_ext_current_limit_i = 16'hFFFF, reverse_ext_current_limit_i = 16'hFFFF;
   logic [QW-1:0] analog_torque_input_i = 16'hFFFF, velocity_limit_setting_i = 16'hFFFF;
   logic [QW-1:0] analog_speed_limit_i = 16'hFFFF, internal_regen_tolerance_i = 16'hFFFF;
   logic [QW-1:0] regen_resistor_capacity_i = 16'hFFFF, rated_torque_i = 16'h0064;
   logic [FACTOR_W-1:0] pulse_factor_value_i = 8'h01;
   logic [N_TERM*SEL_W-1:0] term_alloc_i = TERM_ALLOC_RST;
   logic fault_free_output_o, position_done_flag_a_o, position_done_flag_b_o, servo_ready_o;
   logic speed_match_output_o, rotation_detect_output_o, torque_limit_hit_output_o;
   logic velocity_limit_hit_output_o, brake_interlock_output_o, warning_output_o;
   logic pulse_factor_active_output_o;
   logic [FAULT_W-1:0] fault_code_o, host_code;
   logic [FACTOR_W-1:0] applied_factor_o;
   logic [N_TERM-1:0] term_out_o, host_term;
   int n_mismatch = 0;
   int n_tests = 0;

   sso_status_out uut (.*);
   sso_host_model host (.clk_sys_i(clk_sys_i), .term_out_i(term_out_o),
      .fault_code_i(fault_code_o), .host_term_o(host_term), .host_code_o(host_code));

   always #10 clk_sys_i = ~clk_sys_i;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Eight cycles covers the slowest path, the synchronised pins
   task automatic wt(input int n = 8);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic final_report();
      if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Watchdog; the sequence needs well under 1000 cycles
   initial begin
      #40000;
      n_mismatch++;
      final_report();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      wt(20);
      chk(fault_free_output_o, 1'b0);
      chk(warning_output_o, 1'b1);
      chk(applied_factor_o, 8'h01);
      resetn_i = 1'b1;
      main_power_ok_i = 1'b1;
      wt();
      chk(fault_free_output_o, 1'b0);
      init_done_i = 1'b1;
      wt();
      chk(fault_free_output_o, 1'b1);
      chk(servo_ready_o, 1'b1);
      chk(host_term[3], 1'b1);
      position_done_range_a_i = 16'h0010;
      deviation_abs_i = 16'h000F;
      wt();
      chk(position_done_flag_a_o, 1'b1);
      chk(host_term[0], 1'b1);
      deviation_abs_i = 16'h0010;
      wt();
      chk(position_done_flag_a_o, 1'b0);
      chk(position_done_flag_b_o, 1'b1);
      position_done_range_b_i = 16'h0010;
      wt();
      chk(position_done_flag_b_o, 1'b0);
      deviation_abs_i = 16'h0000;
      control_mode_i = 2'h1;
      speed_cmd_i = 16'h03E8;
      speed_i = 16'h041A;
      speed_match_width_i = 16'h0032;
      wt();
      chk({position_done_flag_a_o, position_done_flag_b_o}, 2'b00);
      chk(speed_match_output_o, 1'b1);
      speed_i = 16'h041B;
      rotation_detect_speed_i = 16'h041A;
      wt();
      chk(speed_match_output_o, 1'b0);
      chk(rotation_detect_output_o, 1'b1);
      speed_i = 16'h041A;
      control_mode_i = 2'h2;
      velocity_limit_setting_i = 16'h041A;
      wt();
      chk(speed_match_output_o, 1'b0);
      chk(rotation_detect_output_o, 1'b0);
      chk(velocity_limit_hit_output_o, 1'b1);
      velocity_limit_setting_i = 16'hFFFF;
      speed_input_selector_i = 2'h1;
      analog_speed_limit_i = 16'h041A;
      torque_i = 16'h00C8;
      forward_torque_limit_i = 16'h00C8;
      wt();
      chk(velocity_limit_hit_output_o, 1'b1);
      chk(torque_limit_hit_output_o, 1'b1);
      control_mode_i = 2'h1;
      forward_torque_limit_i = 16'h00C9;
      forward_ext_current_limit_i = 16'h00C8;
      analog_torque_input_i = 16'h00C8;
      torque_input_selector_i = 2'h3;
      wt();
      chk(velocity_limit_hit_output_o, 1'b0);
      chk(torque_limit_hit_output_o, 1'b0);
      forward_ext_current_limit_input_i = 1'b1;
      wt();
      chk(torque_limit_hit_output_o, 1'b1);
      forward_ext_current_limit_input_i = 1'b0;
      forward_ext_current_limit_i = 16'hFFFF;
      wt();
      chk(torque_limit_hit_output_o, 1'b0);
      torque_input_selector_i = 2'h1;
      torque_eff_i = 16'h0073;
      wt();
      chk(torque_limit_hit_output_o, 1'b1);
      chk(warning_output_o, 1'b1);
      torque_eff_i = 16'h0074;
      wt();
      chk(warning_output_o, 1'b0);
      torque_eff_i = 16'h0000;
      regen_energy_i = 16'h0010;
      internal_regen_tolerance_i = 16'h000F;
      wt();
      chk(warning_output_o, 1'b0);
      internal_regen_tolerance_i = 16'hFFFF;
      external_resistor_i = 1'b1;
      regen_resistor_capacity_i = 16'h000F;
      pulse_factor_value_i = 8'h04;
      pulse_factor_select_i = 1'b1;
      wt();
      chk(warning_output_o, 1'b0);
      chk({pulse_factor_active_output_o, applied_factor_o}, 9'h001);
      pulse_factor_switch_enable_i = 1'b1;
      wt();
      chk({pulse_factor_active_output_o, applied_factor_o}, 9'h104);
      term_alloc_i = {ST_WARN, ST_BRAKE, ST_PFACT, ST_TRQ_LIM};
      pulse_factor_select_i = 1'b0;
      brake_timing_one_i = 16'h0005;
      servo_on_i = 1'b1;
      wt(4);
      chk(brake_interlock_output_o, 1'b0);
      wt();
      chk({pulse_factor_active_output_o, applied_factor_o}, 9'h001);
      chk(brake_interlock_output_o, 1'b1);
      chk(host_term, 4'h5);
      brake_command_speed_i = 16'hFFFF;
      servo_on_i = 1'b0;
      fault_code_i = 3'h5;
      fault_i = 1'b1;
      term_alloc_i = {ST_VEL_LIM, ST_POS_B, ST_SPD_MT, ST_POS_A};
      wt(2);
      chk(fault_free_output_o, 1'b0);
      chk(fault_code_o, 3'h5);
      chk(servo_ready_o, 1'b0);
      wt();
      chk(host_code, 3'h5);
      chk(host_term, 4'h2);
      chk(brake_interlock_output_o, 1'b0);
      final_report();
   end
endmodule
